//--- core/swpc_config.sv
`timescale 1ns/1ps
`default_nettype none
module swpc_config
  import swpc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Command decode from host port
  input wire logic i_dev_reset_cmd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_byte,
  input wire logic i_set_rptr,
  input wire logic [1:0] i_set_rptr_val,
  input wire logic i_bus_cmd,
  input wire logic i_port_cmd,
  // Bus timing events
  input wire swpc_slot_s i_slot,
  input wire logic i_sleep_n_input,
  // Host readback
  input wire logic [7:0] i_status_byte,
  input wire logic [7:0] i_data_byte,
  input wire logic [7:0] i_port_byte,
  output logic [7:0] o_rd_data,
  output logic [1:0] o_rd_ptr,
  output logic o_cfg_nack,
  output logic o_dev_reset_flag,
  // Bus drive
  output swpc_cfg_s o_cfg_active,
  output logic o_pullup_resistor_en,
  output logic o_bus_force_low,
  output logic o_low_z_pullup,
  output logic o_bus_refuse,
  output logic o_sleep
);
  typedef struct packed {
    swpc_cfg_s cfg;
    swpc_cfg_s act;
    logic [1:0] rptr;
    logic nack;
    logic rst_flag;
  } swpc_state_s;
  swpc_state_s q, next_q;
  logic strong_done;
  logic strong_stop;

  // An accepted write with the strong bit at zero, a device reset or a new bus command ends the strong phase
  assign strong_stop = i_bus_cmd || i_dev_reset_cmd
    || (i_cfg_wr && swpc_cfg_ok(i_cfg_byte) && !i_cfg_byte[CFG_STRONG_BIT]); // R16

  always_comb begin
    next_q = q;
    next_q.nack = 1'b0;
    if (i_dev_reset_cmd) begin
      next_q.cfg = swpc_cfg_s'(CFG_RESET[3:0]); // R03
      next_q.act = swpc_cfg_s'(CFG_RESET[3:0]);
      next_q.rptr = RPTR_STATUS; // R01
      next_q.rst_flag = 1'b1;
    end else begin
      if (i_cfg_wr) begin
        next_q.rptr = RPTR_CONFIG; // R01
        if (swpc_cfg_ok(i_cfg_byte)) begin // R04
          next_q.cfg.overdrive_speed_sel = i_cfg_byte[CFG_SPEED_BIT]; // R06
          next_q.cfg.strong_pullup_en = i_cfg_byte[CFG_STRONG_BIT]
            && !i_cfg_byte[CFG_PDN_BIT]; // R12
          next_q.cfg.bus_power_down = i_cfg_byte[CFG_PDN_BIT];
          next_q.cfg.active_pullup_en = i_cfg_byte[CFG_ACTIVE_BIT];
          next_q.rst_flag = 1'b0; // R22
        end else begin
          next_q.nack = 1'b1; // R21
          // A refused byte must not keep a finished strong phase alive
          if (strong_done) begin
            next_q.cfg.strong_pullup_en = 1'b0; // R02
          end
        end
      end else if (strong_done) begin
        next_q.cfg.strong_pullup_en = 1'b0; // R02 R17
      end
      if (i_set_rptr) begin
        next_q.rptr = i_set_rptr_val;
      end else if (i_bus_cmd) begin
        next_q.rptr = RPTR_STATUS;
      end else if (i_port_cmd) begin
        next_q.rptr = RPTR_PORT;
      end
      // Never switch timing mid slot; power-down applies at once
      if (i_slot.slot_start || i_bus_cmd) begin
        next_q.act = next_q.cfg; // R23 R18 R20
      end else begin
        next_q.act.bus_power_down = next_q.cfg.bus_power_down;
        next_q.act.strong_pullup_en = next_q.cfg.strong_pullup_en;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= '{cfg: swpc_cfg_s'(4'h0), act: swpc_cfg_s'(4'h0), rptr: RPTR_STATUS,
             nack: 1'b0, rst_flag: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  swpc_pullup swpc_pullup_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst || i_dev_reset_cmd),
    .i_apu(q.act.active_pullup_en),
    .i_spu(q.cfg.strong_pullup_en),
    .i_od(q.act.overdrive_speed_sel),
    .i_pdn(q.cfg.bus_power_down),
    .i_strong_stop(strong_stop),
    .i_slot(i_slot),
    .o_low_z_pullup(o_low_z_pullup),
    .o_strong_done(strong_done)
  );

  always_comb begin
    case (q.rptr)
      RPTR_CONFIG: o_rd_data = {4'h0, q.cfg}; // R05
      RPTR_STATUS: o_rd_data = i_status_byte;
      RPTR_DATA: o_rd_data = i_data_byte;
      RPTR_PORT: o_rd_data = i_port_byte;
      default: o_rd_data = 8'h00;
    endcase
  end

  assign o_rd_ptr = q.rptr;
  assign o_cfg_nack = q.nack;
  assign o_dev_reset_flag = q.rst_flag;
  assign o_cfg_active = q.act;
  assign o_sleep = !i_sleep_n_input; // R13
  assign o_pullup_resistor_en = !q.cfg.bus_power_down; // R11 R13
  assign o_bus_force_low = q.cfg.bus_power_down; // R11 R13
  assign o_bus_refuse = q.cfg.bus_power_down || !i_sleep_n_input; // R11

  bad_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R04
    (i_cfg_wr && !i_dev_reset_cmd && !swpc_cfg_ok(i_cfg_byte))
    |=> (o_cfg_nack
      && q.cfg.overdrive_speed_sel == $past(q.cfg.overdrive_speed_sel)
      && q.cfg.bus_power_down == $past(q.cfg.bus_power_down)
      && q.cfg.active_pullup_en == $past(q.cfg.active_pullup_en)
      && q.cfg.strong_pullup_en == ($past(q.cfg.strong_pullup_en) && !$past(strong_done))))
    else $error("bad config byte not refused");
  good_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R06 R22
    (i_cfg_wr && !i_dev_reset_cmd && swpc_cfg_ok(i_cfg_byte))
    |=> ({q.cfg.overdrive_speed_sel, q.cfg.bus_power_down, q.cfg.active_pullup_en}
      == {$past(i_cfg_byte[3]), $past(i_cfg_byte[1]), $past(i_cfg_byte[0])}
      && !o_dev_reset_flag))
    else $error("config write not applied");
  pdn_spu_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R12
    q.cfg.bus_power_down |-> !q.cfg.strong_pullup_en)
    else $error("strong pullup stored with power-down");
  reset_cfg_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R03
    i_dev_reset_cmd |=> (o_rd_ptr == RPTR_STATUS && q.cfg == 4'h0))
    else $error("device reset left config set");
  upper_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R05
    (o_rd_ptr == RPTR_CONFIG) |-> (o_rd_data[7:4] == 4'h0))
    else $error("upper nibble nonzero");
  pdn_bus_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R11
    q.cfg.bus_power_down |-> (o_bus_force_low && !o_low_z_pullup && o_bus_refuse))
    else $error("power-down not holding bus low");
  strong_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R02
    (strong_done && !i_cfg_wr && !i_dev_reset_cmd)
    |=> (!q.cfg.strong_pullup_en && q.cfg.active_pullup_en == $past(q.cfg.active_pullup_en)))
    else $error("strong pullup bit not cleared");
  cfg_ptr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R01
    (i_cfg_wr && !i_dev_reset_cmd && !i_set_rptr && !i_bus_cmd && !i_port_cmd)
    |=> (o_rd_ptr == RPTR_CONFIG))
    else $error("read pointer not at config");
  act_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R23
    (!i_slot.slot_start && !i_bus_cmd && !i_dev_reset_cmd)
    |=> (o_cfg_active.overdrive_speed_sel == $past(o_cfg_active.overdrive_speed_sel)
      && o_cfg_active.active_pullup_en == $past(o_cfg_active.active_pullup_en)))
    else $error("speed changed inside a slot");
endmodule
`default_nettype wire

//--- core/swpc_pkg.sv
// Operation
// (R01) Read pointer follows last executed instruction
// (R02) Features combine; strong pullup self-clears after use
// (R03) Config reads zero after any reset
// (R04) Write accepted only with complement upper nibble
// (R05) Upper config nibble always reads zero
// (R06) Bits: speed 3, strong 2, power-down 1, active 0
// (R07) Active pullup off: resistor only on rises
// (R08) Active pullup on from threshold to slot end
// (R09) No active pullup after short recovery
// (R10) Fixed pullup on reset/presence rising edges
// (R11) Power-down: pullup off, bus low, no traffic
// (R12) Power-down with strong pullup stores strong zero
// (R13) Sleep input low: bus per power-down bit
// (R14) Host sets strong pullup right before command
// (R15) Strong pullup engages at slot rise threshold
// (R16) Strong pullup ends on command, clear, reset
// (R17) Strong pullup leaves active pullup bit alone
// (R18) Speed bit selects standard or overdrive timing
// (R19) Host sets speed after overdrive byte command
// (R20) Speed zero then bus reset returns standard
// (R21) Failed config byte answered with not-acknowledge
// (R22) Config write clears device-reset status flag
// (R23) Changes apply from next slot or command
package swpc_pkg;
  localparam logic [1:0] RPTR_CONFIG = 2'h0;
  localparam logic [1:0] RPTR_STATUS = 2'h1;
  localparam logic [1:0] RPTR_DATA = 2'h2;
  localparam logic [1:0] RPTR_PORT = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_SPEED_BIT = 3;
  localparam int CFG_STRONG_BIT = 2;
  localparam int CFG_PDN_BIT = 1;
  localparam int CFG_ACTIVE_BIT = 0;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FIX_PU_STD_NS = 2500;
  localparam int FIX_PU_OD_NS = 500;
  localparam logic [9:0] FIX_PU_STD_CYC = 10'((FIX_PU_STD_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [9:0] FIX_PU_OD_CYC = 10'((FIX_PU_OD_NS * 1000) / CLK_PERIOD_PS);

  typedef struct packed {
    logic overdrive_speed_sel;
    logic strong_pullup_en;
    logic bus_power_down;
    logic active_pullup_en;
  } swpc_cfg_s;

  typedef struct packed {
    logic slot_start;
    logic slot_end;
    logic rise_hi_thr;
    logic rise_apu_thr;
    logic short_recovery;
    logic rst_rise;
  } swpc_slot_s;

  typedef enum logic [1:0] {PU_IDLE, PU_ACTIVE, PU_FIXED, PU_STRONG} swpc_pu_e;

  function automatic logic swpc_cfg_ok(input logic [7:0] b);
    return b[7:4] == ~b[3:0];
  endfunction
endpackage

//--- core/swpc_pullup.sv
`timescale 1ns/1ps
`default_nettype none
module swpc_pullup
  import swpc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Speed and active pullup latched at slot boundary, the rest taken directly
  input wire logic i_apu,
  input wire logic i_spu,
  input wire logic i_od,
  input wire logic i_pdn,
  input wire logic i_strong_stop,
  input wire swpc_slot_s i_slot,
  // Pullup controls
  output logic o_low_z_pullup,
  output logic o_strong_done
);
  typedef struct packed {
    swpc_pu_e st;
    logic [9:0] cnt;
    logic done;
  } swpc_pu_state_s;
  swpc_pu_state_s q, next_q;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    case (q.st)
      PU_IDLE: begin
        if (i_pdn) begin
          next_q.st = PU_IDLE; // R11
        end else if (i_slot.short_recovery) begin
          next_q.st = PU_IDLE; // R09
        end else if (i_spu && (i_apu ? i_slot.rise_apu_thr : i_slot.rise_hi_thr)) begin
          next_q.st = PU_STRONG; // R15
        end else if (i_apu && i_slot.rst_rise) begin
          next_q.st = PU_FIXED; // R10
          next_q.cnt = i_od ? FIX_PU_OD_CYC : FIX_PU_STD_CYC;
        end else if (i_apu && i_slot.rise_apu_thr) begin
          next_q.st = PU_ACTIVE; // R08
        end
      end
      PU_ACTIVE: begin
        if (i_slot.slot_end || i_pdn) begin
          next_q.st = PU_IDLE; // R08
        end
      end
      PU_FIXED: begin
        if (q.cnt <= 10'h001 || i_pdn) begin
          next_q.st = PU_IDLE;
        end else begin
          next_q.cnt = q.cnt - 10'h001; // R10
        end
      end
      PU_STRONG: begin
        if (i_strong_stop || i_pdn) begin
          next_q.st = PU_IDLE; // R16
          next_q.done = 1'b1;
        end
      end
      default: next_q.st = PU_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= '{st: PU_IDLE, cnt: 10'h000, done: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // Resistor-only unless a low-impedance phase is running
  // Power-down cuts the transistor at once, not one cycle later
  assign o_low_z_pullup = (q.st != PU_IDLE) && !i_pdn; // R07 R11
  assign o_strong_done = q.done;

  sequence fixed_start_s;
    q.st == PU_IDLE && next_q.st == PU_FIXED && !i_od;
  endsequence
  sequence fixed_hold_s;
    (o_low_z_pullup || i_pdn) [*8];
  endsequence
  fixed_len_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R10
    fixed_start_s |=> fixed_hold_s)
    else $error("fixed pullup ended early");
  no_short_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R09
    (q.st == PU_IDLE && i_slot.short_recovery) |=> !o_low_z_pullup)
    else $error("pullup after short recovery");
  active_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R08
    (q.st == PU_ACTIVE && i_slot.slot_end) |=> !o_low_z_pullup)
    else $error("active pullup beyond slot end");
endmodule
`default_nettype wire

//--- tb/swpc_slot_model.sv
`timescale 1ns/1ps
`default_nettype none
module swpc_slot_model
  import swpc_pkg::*;
(
  // Clock
  input wire logic i_clk_sys,
  // Slot request, slave hold time and rise shape
  input wire logic i_go,
  input wire logic [3:0] i_gap,
  input wire logic [1:0] i_mode,
  // Slot events
  output swpc_slot_s o_slot
);
  logic [4:0] cnt = 5'h0;
  logic [4:0] last;
  assign last = {1'b0, i_gap} + 5'h4;
  always_ff @(posedge i_clk_sys) begin
    if (i_go) begin
      cnt <= 5'h1;
    end else if (cnt == last) begin
      cnt <= 5'h0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt + 5'h1;
    end
  end
  // Mode 1 rises out of a short, 2 is a reset rise, 3 stalls below the high threshold
  assign o_slot = '{slot_start: cnt == 5'h1, slot_end: cnt == last,
    rise_hi_thr: cnt == 5'h3 && !i_mode[1],
    rise_apu_thr: cnt == 5'h2 && i_mode != 2'h2,
    short_recovery: cnt == 5'h2 && i_mode == 2'h1,
    rst_rise: cnt == 5'h2 && i_mode == 2'h2};
endmodule
`default_nettype wire

//--- tb/single_wire_port_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module single_wire_port_config_tb;
  import swpc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic drst = 1'b0, wr = 1'b0, srp = 1'b0, bcmd = 1'b0, pcmd = 1'b0, go = 1'b0, slp_n = 1'b1;
  logic [7:0] cb = 8'h0, sb = 8'h0, db = 8'h0, pb = 8'h0, rd, ec, b;
  logic [1:0] sv = 2'h0, ptr;
  logic [3:0] lo, gap = 4'h0;
  logic [1:0] mode = 2'h0;
  logic nack, rflag, pres, flow, lowz, refuse, sleep, fe;
  swpc_cfg_s act;
  swpc_slot_s slot;
  int fail_count = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  swpc_config swpc_config_inst (.i_clk_sys(clk), .i_rst(rst), .i_dev_reset_cmd(drst),
    .i_cfg_wr(wr), .i_cfg_byte(cb), .i_set_rptr(srp), .i_set_rptr_val(sv), .i_bus_cmd(bcmd),
    .i_port_cmd(pcmd), .i_slot(slot), .i_sleep_n_input(slp_n), .i_status_byte(sb),
    .i_data_byte(db), .i_port_byte(pb), .o_rd_data(rd), .o_rd_ptr(ptr), .o_cfg_nack(nack),
    .o_dev_reset_flag(rflag), .o_cfg_active(act), .o_pullup_resistor_en(pres),
    .o_bus_force_low(flow), .o_low_z_pullup(lowz), .o_bus_refuse(refuse), .o_sleep(sleep));
  swpc_slot_model swpc_slot_model_inst (.i_clk_sys(clk), .i_go(go), .i_gap(gap), .i_mode(mode),
    .o_slot(slot));
  task end_sim();
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmd(input int k, input logic [7:0] v);
    @(posedge clk);
    case (k)
      0: drst <= 1'b1;
      1: begin
        wr <= 1'b1;
        cb <= v;
      end
      2: begin
        srp <= 1'b1;
        sv <= v[1:0];
      end
      3: bcmd <= 1'b1;
      4: pcmd <= 1'b1;
      default: go <= 1'b1;
    endcase
    @(posedge clk);
    {drst, wr, srp, bcmd, pcmd, go} <= 6'h0;
    #1;
  endtask
  // Bounded wait for the far side to close its slot
  task automatic slot_run();
    int n;
    n = 0;
    cmd(5, 8'h0);
    while (slot.slot_end !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) fail_count++;
  endtask
  // Length of one low-impedance phase in clock cycles
  task automatic len_run(input logic [15:0] e);
    int n;
    n = 0;
    cmd(5, 8'h0);
    while (lowz !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (lowz === 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(e, 16'(n));
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] o, input logic [7:0] v);
    if (v[7:4] != ~v[3:0]) return o;
    return {4'h0, v[3], v[2] & ~v[1], v[1:0]};
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h2511));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(8'h1, {6'h0, ptr});
    chk(8'h1, {7'h0, rflag});
    @(posedge clk);
    sb <= 8'($urandom);
    db <= 8'($urandom);
    pb <= 8'($urandom);
    for (int k = 0; k < 4; k++) begin
      cmd(2, 8'(k));
      chk(k == 0 ? 8'h0 : k == 1 ? sb : k == 2 ? db : pb, rd);
    end
    cmd(3, 8'h0);
    chk(8'h1, {6'h0, ptr});
    cmd(4, 8'h0);
    chk(8'h3, {6'h0, ptr});
    ec = 8'h0;
    fe = 1'b1;
    for (int i = 0; i < 40; i++) begin
      lo = 4'($urandom);
      b = {($urandom % 2) ? ~lo : 4'($urandom), lo};
      if (i == 0) b = 8'h96;
      cmd(1, b);
      chk({7'h0, b[7:4] != ~b[3:0]}, {7'h0, nack});
      ec = nxt(ec, b);
      if (b[7:4] == ~b[3:0]) fe = 1'b0;
      cmd(2, 8'h0);
      chk(ec, rd);
      chk({7'h0, fe}, {7'h0, rflag});
      chk({5'h0, ec[1], ec[1], ~ec[1]}, {5'h0, refuse, flow, pres});
    end
    cmd(0, 8'h0);
    cmd(2, 8'h0);
    chk(8'h0, rd);
    @(posedge clk);
    slp_n <= 1'b0;
    cmd(2, 8'h0);
    chk(8'h5, {5'h0, sleep, flow, pres});
    @(posedge clk);
    slp_n <= 1'b1;
    foreach (ec[j]) begin
      if (j < 2) begin
        gap <= 4'($urandom);
        cmd(1, j == 0 ? 8'he1 : 8'hf0);
        slot_run();
        chk({7'h0, j == 0}, {7'h0, lowz});
        cmd(2, 8'h0);
        chk(8'h0, {7'h0, lowz});
      end
    end
    cmd(1, 8'h78);
    chk(8'h0, {7'h0, act.overdrive_speed_sel});
    cmd(1, 8'h2d);
    slot_run();
    chk(8'h1, {7'h0, act.overdrive_speed_sel});
    repeat (3) @(posedge clk);
    #1;
    chk(8'h1, {7'h0, lowz});
    cmd(3, 8'h0);
    cmd(2, 8'h0);
    chk(8'h0, {7'h0, lowz});
    chk(8'h09, rd);
    mode <= 2'h2;
    len_run({6'h0, FIX_PU_OD_CYC});
    cmd(1, 8'he1);
    len_run({6'h0, FIX_PU_STD_CYC});
    mode <= 2'h1;
    slot_run();
    chk(8'h0, {7'h0, lowz});
    cmd(1, 8'h3c);
    mode <= 2'h3;
    slot_run();
    chk(8'h0, {7'h0, lowz});
    mode <= 2'h0;
    slot_run();
    chk(8'h1, {7'h0, lowz});
    cmd(3, 8'h0);
    cmd(1, 8'hf0);
    slot_run();
    chk(8'h0, {7'h0, act.overdrive_speed_sel});
    end_sim();
  end
endmodule
`default_nettype wire
